// File: dv/gcd_trig_src.sv
/*
 * Trigger source model: external trigger pulses and the direct gate.
 * Assumes requests arrive from the bench on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module gcd_trig_src (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bench requests
    input wire logic fire,
    input wire logic pol,
    input wire logic gate_req,
    // pins
    output logic ext_trig,
    output logic direct_gate
);
    logic [1:0] hold_q;
    // pulse long enough for the two-flop synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= 2'h0;
        end else if (fire) begin
            hold_q <= 2'h3;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end
    assign ext_trig = pol ^ (hold_q != 2'h0);
    // gate timing and width come straight from the bench's gate_req
    assign direct_gate = gate_req;
endmodule
`default_nettype wire

// File: dv/tb.sv
/*
 * Self-checking bench for the delay generator: APB tasks, sequences.
 * Assumes zero-wait APB and the sequence timing of the hand-over.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
    import gcd_pkg::*;
;
    logic CLOCK, RST_B, PSEL, PENABLE, PWRITE, READOUT_DONE, err, pc_prev;
    logic PREADY, PSLVERR, EXT_TRIG, DIRECT_GATE, PHOTOCATHODE_ON;
    logic EXPOSURE_OUT, TRIG_READY, FLUSH_ACTIVE, READOUT_START;
    logic TRIG_TERM_EN, fire, pol, gate_req;
    logic [7:0] PADDR, TRIG_THRESH;
    logic [31:0] PWDATA, PRDATA, rdat;
    logic [2:0] AUX_OUT;
    logic [3:0] sig;
    int failures, check_count, rises, r0, ex, rs, fl, n;
    int first[4], hc[4];
    int exf[4] = '{5, 2, 3, 7};
    int exh[4] = '{3, 1, 1, 1};
    logic [7:0] pa[7] = '{8'h10, 8'h14, 8'h30, 8'h18, 8'h20, 8'h28, 8'h08};
    logic [31:0] pd[7] = '{32'hFA1, 32'h0, 32'h1770, 32'h0, 32'h7D0,
        32'h2710, 32'hA};

    gcd_delay_gen gcd_delay_gen_i (.CLOCK(CLOCK), .RST_B(RST_B),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .EXT_TRIG(EXT_TRIG), .DIRECT_GATE(DIRECT_GATE),
        .READOUT_DONE(READOUT_DONE), .PHOTOCATHODE_ON(PHOTOCATHODE_ON),
        .AUX_OUT(AUX_OUT), .EXPOSURE_OUT(EXPOSURE_OUT),
        .TRIG_READY(TRIG_READY), .FLUSH_ACTIVE(FLUSH_ACTIVE),
        .READOUT_START(READOUT_START), .TRIG_TERM_EN(TRIG_TERM_EN),
        .TRIG_THRESH(TRIG_THRESH));
    gcd_trig_src gcd_trig_src_i (.clk(CLOCK), .rst_b(RST_B), .fire(fire),
        .pol(pol), .gate_req(gate_req), .ext_trig(EXT_TRIG),
        .direct_gate(DIRECT_GATE));

    // ----------------------------------------------------------
    // clock, gate pulse counter, tasks
    // ----------------------------------------------------------
    initial begin
        CLOCK = 1'b0;
        forever #10 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        pc_prev <= PHOTOCATHODE_ON;
        if (PHOTOCATHODE_ON === 1'b1 && pc_prev === 1'b0) rises <= rises + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // inputs change by nba at the edge, outputs sampled 1 ns later
    task automatic step(input logic f, input logic r);
        @(posedge CLOCK);
        fire <= f;
        READOUT_DONE <= r;
        #1;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        // no local limit: only the watchdog ends a stuck access
        do begin
            @(posedge CLOCK);
        end while (PREADY !== 1'b1);
        rdat = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    function automatic logic sel(input int k);
        case (k)
            0: return TRIG_READY;
            1: return EXPOSURE_OUT;
            default: return FLUSH_ACTIVE;
        endcase
    endfunction
    // bounded wait; cycles taken are left in n
    task automatic await(input int k, input logic v);
        n = 0;
        while (sel(k) !== v && n < 1000) begin
            step(1'b0, 1'b0);
            n++;
        end
        chk({31'h0, sel(k)}, {31'h0, v});
    endtask

    // ----------------------------------------------------------
    // sequences
    // ----------------------------------------------------------
    initial begin
        RST_B = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
        PADDR = 8'h00; PWDATA = 32'h0; READOUT_DONE = 1'b0; fire = 1'b0;
        pol = 1'b0; gate_req = 1'b0; rises = 0;
        repeat (8) @(posedge CLOCK);
        RST_B <= 1'b1;
        rd(OFF_CTRL, CTRL_RST);
        rd(OFF_EXPOSE, EXPOSE_RST);
        rd(OFF_AUX_WIDTH, AUX_WIDTH_RST);
        rd(8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(1'b1, OFF_DLY_BASE, 32'hD4A51000);
        xfer(1'b1, OFF_DLY_BASE + 8'h04, 32'h000000E8);
        rd(OFF_DLY_BASE, 32'hD4A51000);
        rd(OFF_DLY_BASE + 8'h04, 32'h000000E8);
        for (int k = 0; k < 7; k++) xfer(1'b1, pa[k], pd[k]);
        rd(OFF_GWID_LO, 32'h1770);
        xfer(1'b1, OFF_CTRL, 32'h00A50205);
        step(1'b0, 1'b0);
        chk({31'h0, TRIG_TERM_EN}, 32'h1);
        chk({24'h0, TRIG_THRESH}, 32'hA5);
        // new polarity needs the channel flop and the output flop
        step(1'b0, 1'b0);
        chk({29'h0, AUX_OUT}, 32'h2);
        await(0, 1'b1);
        rd(OFF_STATUS, 32'h5);
        step(1'b1, 1'b0);
        await(1, 1'b1);
        first = '{-1, -1, -1, -1};
        hc = '{0, 0, 0, 0};
        ex = 0;
        rs = 0;
        for (int i = 0; i < 30; i++) begin
            if (i > 0) step(1'b0, 1'b0);
            sig = {AUX_OUT ^ 3'b010, PHOTOCATHODE_ON};
            for (int k = 0; k < 4; k++) if (sig[k] === 1'b1) begin
                if (first[k] < 0) first[k] = i;
                hc[k]++;
            end
            ex += (EXPOSURE_OUT === 1'b1);
            rs += (READOUT_START === 1'b1);
        end
        for (int k = 0; k < 4; k++) begin
            chk(32'(first[k]), 32'(exf[k]));
            chk(32'(hc[k]), 32'(exh[k]));
        end
        chk(32'(ex), 32'hA);
        chk(32'(rs), 32'h1);
        chk({31'h0, TRIG_READY}, 32'h0);
        // a trigger during flush without the fast option is dropped
        ex = 0;
        fl = 0;
        step(1'b0, 1'b1);
        for (int i = 0; i < 1000 && TRIG_READY !== 1'b1; i++) begin
            step(i == 20, 1'b0);
            ex += (EXPOSURE_OUT === 1'b1);
            fl += (FLUSH_ACTIVE === 1'b1);
        end
        chk(32'(ex), 32'h0);
        chk(32'(fl), 32'(FLUSH_CYC));
        xfer(1'b1, OFF_CTRL, 32'h00A5022D);
        xfer(1'b1, OFF_EXPOSE, 32'hFA);
        step(1'b1, 1'b0);
        await(1, 1'b1);
        r0 = rises;
        repeat (100) step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        repeat (60) step(1'b0, 1'b0);
        chk(32'(rises - r0), 32'h2);
        await(0, 1'b0);
        step(1'b0, 1'b1);
        await(2, 1'b1);
        step(1'b1, 1'b0);
        await(1, 1'b1);
        chk(32'(n < 8), 32'h1);
        chk({31'h0, FLUSH_ACTIVE}, 32'h0);
        // falling-edge trigger: pin idles high, fast start from flush
        xfer(1'b1, OFF_CTRL, 32'h00A5022F);
        pol <= 1'b1;
        await(0, 1'b0);
        step(1'b0, 1'b1);
        await(2, 1'b1);
        step(1'b1, 1'b0);
        await(1, 1'b1);
        chk(32'(n), 32'h4);
        xfer(1'b1, OFF_CTRL, 32'h00000010);
        @(posedge CLOCK) gate_req <= 1'b1;
        #10 chk({31'h0, PHOTOCATHODE_ON}, 32'h1);
        @(posedge CLOCK) gate_req <= 1'b0;
        #10 chk({31'h0, PHOTOCATHODE_ON}, 32'h0);
        tally_and_finish();
    end
    // hang guard, far beyond the under two thousand cycles used
    initial begin
        repeat (20000) @(posedge CLOCK);
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: inc/gcd_chan_if.sv
/*
 * Link between the delay generator core and one delay channel.
 * Assumes the core drives settings each cycle and reads the output.
 */
`timescale 1ns/1ps
`default_nettype none
interface gcd_chan_if #(parameter int unsigned W = 40);
    logic start;
    logic [W-1:0] delay;
    logic [W-1:0] width;
    logic pol;
    logic out;
    modport ctl(output start, output delay, output width, output pol,
        input out);
    modport chan(input start, input delay, input width, input pol,
        output out);
endinterface
`default_nettype wire

// File: inc/gcd_pkg.sv
/*
 * Shared constants for the gated camera delay generator: timing,
 * register offsets, control field positions and reset values.
 * Assumes a single 50 MHz clock and a 32-bit APB register port.
 */
package gcd_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 20000;
    localparam int unsigned RES_PS = 10;
    localparam int unsigned TIME_W = 40;
    localparam logic [TIME_W:0] STEP_UNITS =
        (TIME_W + 1)'(CLK_PERIOD_PS / RES_PS);
    localparam int unsigned FLUSH_TIME_NS = 10000;
    localparam logic [15:0] FLUSH_CYC =
        16'((FLUSH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned NUM_AUX = 3;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_EXPOSE = 8'h08;
    localparam logic [7:0] OFF_AUX_WIDTH = 8'h0C;
    localparam logic [7:0] OFF_DLY_BASE = 8'h10;
    localparam logic [7:0] OFF_DLY_STRIDE = 8'h08;
    localparam logic [7:0] OFF_GWID_LO = 8'h30;
    localparam logic [7:0] OFF_GWID_HI = 8'h34;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int unsigned CTL_ACQ_EN = 0;
    localparam int unsigned CTL_TRIG_POL = 1;
    localparam int unsigned CTL_TERM_EN = 2;
    localparam int unsigned CTL_FAST_TRIG = 3;
    localparam int unsigned CTL_BYPASS = 4;
    localparam int unsigned CTL_ACCUM = 5;
    localparam int unsigned CTL_AUX_POL = 8;
    localparam int unsigned CTL_THRESH = 16;
    localparam logic [31:0] CTRL_MASK = 32'h00FF073F;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [31:0] EXPOSE_RST = 32'h00000001;
    localparam logic [31:0] AUX_WIDTH_RST = 32'h000007D0;

endpackage

// File: rtl/gcd_delay_chan.sv
/*
 * One programmable delay channel: after start it waits the delay,
 * then drives its output active for the width, in 10 ps units.
 * Assumes start is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module gcd_delay_chan
    import gcd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // channel link
    gcd_chan_if.chan ch
);
    typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_HIGH} gcd_ch_e;

    gcd_ch_e state_q, state_d;
    logic [TIME_W:0] acc_q, acc_d;
    logic out_q;

    // ------------------------------------------------------------
    // time accumulation
    // ------------------------------------------------------------
    // sub-cycle resolution is kept in the settings only; the pin
    // moves on whole clock edges
    wire logic [TIME_W:0] acc_inc = acc_q + STEP_UNITS;
    wire logic dly_hit = acc_q >= {1'b0, ch.delay};
    wire logic wid_hit = acc_q >= {1'b0, ch.width};
    wire logic wid_zero = ch.width == '0;

    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        if (ch.start) begin
            state_d = CH_WAIT;
            acc_d = '0;
        end else begin
            case (state_q)
                CH_WAIT: begin
                    if (dly_hit) begin
                        state_d = wid_zero ? CH_IDLE : CH_HIGH;
                        acc_d = STEP_UNITS;
                    end else begin
                        acc_d = acc_inc;
                    end
                end
                CH_HIGH: begin
                    if (wid_hit) begin
                        state_d = CH_IDLE;
                        acc_d = '0;
                    end else begin
                        acc_d = acc_inc;
                    end
                end
                CH_IDLE: begin
                    acc_d = '0;
                end
                default: begin
                    state_d = CH_IDLE;
                    acc_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= CH_IDLE;
            acc_q <= '0;
            out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            out_q <= ch.pol ^ (state_d == CH_HIGH);
        end
    end

    assign ch.out = out_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_zero_delay_rise: assert property (
        ch.start && ch.delay == '0 && !wid_zero ##1
        !ch.start && $stable(ch.delay) |=> out_q == !ch.pol)
        else $error("zero delay did not raise output");
    a_out_level: assert property (
        $stable(ch.pol) |-> out_q == (ch.pol ^ (state_q == CH_HIGH)))
        else $error("output level disagrees with state");
    a_width_end: assert property (
        state_q == CH_HIGH && wid_hit && !ch.start
        |=> state_q == CH_IDLE)
        else $error("pulse outlived width");

endmodule
`default_nettype wire

// File: rtl/gcd_delay_gen.sv
/*
 * Delay generator of an intensified camera: trigger handling,
 * exposure sequence, gate and three auxiliary outputs, APB registers.
 * Assumes READOUT_DONE comes from sensor logic on CLOCK; EXT_TRIG
 * and DIRECT_GATE are asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
module gcd_delay_gen
    import gcd_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // trigger and sensor side
    input wire logic EXT_TRIG,
    input wire logic DIRECT_GATE,
    input wire logic READOUT_DONE,
    // outputs
    output logic PHOTOCATHODE_ON,
    output logic [NUM_AUX-1:0] AUX_OUT,
    output logic EXPOSURE_OUT,
    output logic TRIG_READY,
    output logic FLUSH_ACTIVE,
    output logic READOUT_START,
    output logic TRIG_TERM_EN,
    output logic [7:0] TRIG_THRESH
);
    typedef enum logic [2:0] {
        ST_OFF, ST_FLUSH, ST_READY, ST_EXPOSE, ST_READOUT
    } gcd_seq_e;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q, expose_q, aux_wid_q;
    logic [TIME_W-1:0] gwid_q;
    logic [TIME_W-1:0] dly_q [NUM_CH];
    logic [31:0] prdata_q, rd_data;
    logic pready_q, pslverr_q, rd_hit;

    wire logic apb_setup = PSEL && !PENABLE;
    wire logic apb_wr = PSEL && PENABLE && PWRITE && pready_q;
    wire logic wr_ctrl = apb_wr && PADDR == OFF_CTRL;
    wire logic wr_expose = apb_wr && PADDR == OFF_EXPOSE;
    wire logic wr_aux_wid = apb_wr && PADDR == OFF_AUX_WIDTH;
    wire logic wr_gwid_lo = apb_wr && PADDR == OFF_GWID_LO;
    wire logic wr_gwid_hi = apb_wr && PADDR == OFF_GWID_HI;

    wire logic acq_en = ctrl_q[CTL_ACQ_EN];
    wire logic trig_pol = ctrl_q[CTL_TRIG_POL];
    wire logic fast_trig = ctrl_q[CTL_FAST_TRIG];
    wire logic bypass = ctrl_q[CTL_BYPASS];
    wire logic accum = ctrl_q[CTL_ACCUM];
    wire logic [NUM_AUX-1:0] aux_pol = ctrl_q[CTL_AUX_POL +: NUM_AUX];

    gcd_seq_e state_q, state_d;
    logic [31:0] exp_cnt_q;
    logic [15:0] flush_cnt_q;
    logic [NUM_CH-1:0] ch_out;
    logic trig_s1_q, trig_s2_q, trig_prev_q;
    logic expose_out_q, ready_q, flush_q, ro_start_q;
    logic gate_q;
    logic [NUM_AUX-1:0] aux_q;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= CTRL_RST;
            expose_q <= EXPOSE_RST;
            aux_wid_q <= AUX_WIDTH_RST;
            gwid_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= PWDATA & CTRL_MASK;
            if (wr_expose) expose_q <= PWDATA;
            if (wr_aux_wid) aux_wid_q <= PWDATA;
            if (wr_gwid_lo) gwid_q[31:0] <= PWDATA;
            if (wr_gwid_hi) gwid_q[TIME_W-1:32] <= PWDATA[TIME_W-33:0];
        end
    end

    // ------------------------------------------------------------
    // delay channels: 0 is the gate, 1..3 the auxiliary outputs
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] dly_lo_hit, dly_hi_hit;
    wire logic ch_start;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam logic [7:0] LO = 8'(OFF_DLY_BASE + OFF_DLY_STRIDE * i);
        assign dly_lo_hit[i] = PADDR == LO;
        assign dly_hi_hit[i] = PADDR == 8'(LO + 8'h04);

        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                dly_q[i] <= '0;
            end else if (apb_wr && dly_lo_hit[i]) begin
                dly_q[i][31:0] <= PWDATA;
            end else if (apb_wr && dly_hi_hit[i]) begin
                dly_q[i][TIME_W-1:32] <= PWDATA[TIME_W-33:0];
            end
        end

        gcd_chan_if #(.W(TIME_W)) u_if();
        assign u_if.start = ch_start;
        assign u_if.delay = dly_q[i];
        assign u_if.width = (i == 0) ? gwid_q :
            {{(TIME_W - 32){1'b0}}, aux_wid_q};
        assign u_if.pol = (i == 0) ? 1'b0 : aux_pol[(i == 0) ? 0 : i - 1];
        assign ch_out[i] = u_if.out;

        gcd_delay_chan u_chan (
            .clk(CLOCK),
            .rst_b(RST_B),
            .ch(u_if.ctl)
        );
    end

    // ------------------------------------------------------------
    // apb read side
    // ------------------------------------------------------------
    wire logic [31:0] status_w = {24'h000000, 1'b0, gate_q,
        state_q == ST_READOUT, flush_q, expose_out_q, ready_q,
        1'b0, acq_en};

    always_comb begin
        rd_hit = 1'b1;
        rd_data = 32'h00000000;
        case (PADDR)
            OFF_CTRL: rd_data = ctrl_q;
            OFF_STATUS: rd_data = status_w;
            OFF_EXPOSE: rd_data = expose_q;
            OFF_AUX_WIDTH: rd_data = aux_wid_q;
            OFF_GWID_LO: rd_data = gwid_q[31:0];
            OFF_GWID_HI: rd_data = {24'h000000, gwid_q[TIME_W-1:32]};
            default: begin
                rd_hit = 1'b0;
                for (int k = 0; k < NUM_CH; k++) begin
                    if (dly_lo_hit[k]) begin
                        rd_hit = 1'b1;
                        rd_data = dly_q[k][31:0];
                    end
                    if (dly_hi_hit[k]) begin
                        rd_hit = 1'b1;
                        rd_data = {24'h000000, dly_q[k][TIME_W-1:32]};
                    end
                end
            end
        endcase
    end

    // answer prepared in setup so the access phase never waits
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            if (apb_setup) begin
                prdata_q <= PWRITE ? 32'h00000000 : rd_data;
                pslverr_q <= !rd_hit;
            end
        end
    end

    // ------------------------------------------------------------
    // trigger input
    // ------------------------------------------------------------
    // polarity applied after sync
    wire logic trig_lvl = trig_s2_q ^ trig_pol;
    wire logic trig_edge = trig_lvl && !trig_prev_q;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_prev_q <= 1'b1;
        end else begin
            trig_s1_q <= EXT_TRIG;
            trig_s2_q <= trig_s1_q;
            trig_prev_q <= trig_lvl;
        end
    end

    // ------------------------------------------------------------
    // exposure sequence
    // ------------------------------------------------------------
    // fast trigger cuts the flush
    wire logic acc_flush = state_q == ST_FLUSH && fast_trig;
    wire logic acc_accum = state_q == ST_EXPOSE && accum;
    wire logic trig_ok = acq_en &&
        (state_q == ST_READY || acc_flush || acc_accum);
    wire logic trig_acc = trig_edge && trig_ok;
    wire logic exp_end = state_q == ST_EXPOSE && exp_cnt_q <= 32'h1;
    wire logic flush_end = flush_cnt_q >= FLUSH_CYC - 16'h1;
    assign ch_start = trig_acc;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: if (acq_en) state_d = ST_FLUSH;
            ST_FLUSH: begin
                if (trig_acc) state_d = ST_EXPOSE;
                else if (flush_end) state_d = ST_READY;
            end
            ST_READY: if (trig_acc) state_d = ST_EXPOSE;
            ST_EXPOSE: if (exp_end) state_d = ST_READOUT;
            ST_READOUT: if (READOUT_DONE) state_d = ST_FLUSH;
            default: state_d = ST_OFF;
        endcase
        if (!acq_en) state_d = ST_OFF;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_OFF;
            exp_cnt_q <= 32'h00000000;
            flush_cnt_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            if (trig_acc && state_q != ST_EXPOSE) exp_cnt_q <= expose_q;
            else if (state_q == ST_EXPOSE) exp_cnt_q <= exp_cnt_q - 32'h1;
            if (state_q != ST_FLUSH) flush_cnt_q <= 16'h0000;
            else flush_cnt_q <= flush_cnt_q + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            expose_out_q <= 1'b0;
            ready_q <= 1'b0;
            flush_q <= 1'b0;
            ro_start_q <= 1'b0;
            gate_q <= 1'b0;
            aux_q <= '0;
        end else begin
            expose_out_q <= state_d == ST_EXPOSE;
            ready_q <= state_d == ST_READY || state_d == ST_EXPOSE;
            flush_q <= state_d == ST_FLUSH;
            ro_start_q <= exp_end && acq_en;
            gate_q <= ch_out[0];
            aux_q <= ch_out[NUM_CH-1:1];
        end
    end

    // two-level drive, direct path
    // direct gate skips both sync and flop: a sampled path could not
    // meet the insertion bound at this clock rate
    assign PHOTOCATHODE_ON = bypass ? DIRECT_GATE : gate_q;
    assign AUX_OUT = aux_q;
    assign EXPOSURE_OUT = expose_out_q;
    assign TRIG_READY = ready_q;
    assign FLUSH_ACTIVE = flush_q;
    assign READOUT_START = ro_start_q;
    assign TRIG_TERM_EN = ctrl_q[CTL_TERM_EN];
    assign TRIG_THRESH = ctrl_q[CTL_THRESH +: 8];
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    a_gate_follows_chan: assert property (
        !bypass ##1 !bypass |-> PHOTOCATHODE_ON == $past(ch_out[0]))
        else $error("gate does not follow gate channel");
    a_aux_follows: assert property (
        AUX_OUT == $past(ch_out[NUM_CH-1:1]))
        else $error("auxiliary outputs do not follow channels");
    a_marker_rises: assert property (
        state_q == ST_READY && trig_acc |=> EXPOSURE_OUT && !FLUSH_ACTIVE)
        else $error("exposure marker missing after trigger");
    a_ready_falls: assert property (
        exp_end && acq_en |=> !TRIG_READY && READOUT_START ##1
        !READOUT_START)
        else $error("ready not lowered at exposure end");
    a_flush_after_ro: assert property (
        state_q == ST_READOUT && READOUT_DONE && acq_en
        |=> FLUSH_ACTIVE && !TRIG_READY)
        else $error("no flush after readout");
    a_accum_only: assert property (
        trig_acc && state_q == ST_EXPOSE |-> accum && EXPOSURE_OUT)
        else $error("retrigger outside accumulation");
    a_trig_pol: assert property (
        $stable(trig_pol) && !trig_pol && $rose(trig_s2_q) |-> trig_edge)
        else $error("rising edge missed with active-high trigger");
    a_fast_abort: assert property (
        state_q == ST_FLUSH && fast_trig && trig_edge && acq_en
        |=> state_q == ST_EXPOSE && !FLUSH_ACTIVE)
        else $error("fast trigger did not abort flush");
    a_flush_blocks: assert property (
        state_q == ST_FLUSH && !fast_trig && !flush_end
        |=> state_q != ST_EXPOSE)
        else $error("trigger accepted during flush");
    a_direct_gate: assert property (
        bypass |-> PHOTOCATHODE_ON == DIRECT_GATE)
        else $error("direct gate not passed through");
    a_apb_err: assert property (
        apb_setup && !rd_hit |=> PSLVERR && PREADY)
        else $error("unmapped access not flagged");

    c_fast_abort: cover property (
        state_q == ST_FLUSH && trig_acc);
    c_accum_retrig: cover property (
        state_q == ST_EXPOSE && trig_acc);
    c_full_cycle: cover property (
        state_q == ST_READOUT && READOUT_DONE ##[1:600] state_q == ST_READY);

endmodule
`default_nettype wire
